/* File: rtl/gpio_pkg.sv */
/*
  gpio_pkg: shared constants and carrier types for the pin controller.
  assumes: a single 100 MHz clock domain, synchronous active-high reset.
*/
package gpio_pkg;
  // ----------------------------------------------------------------
  // sizes and register selectors
  // ----------------------------------------------------------------
  localparam int PINS_MAX     = 32;
  localparam int EVT_NUM      = 4;
  localparam int SAMPLE_GROUP = 8;
  localparam int SYNC_WAIT    = 2;   // on-demand sampling delay in cycles
  localparam int REG_SEL_W    = 2;
  localparam logic [1:0] SEL_DIR = 2'h0;
  localparam logic [1:0] SEL_OUT = 2'h1;
  localparam logic [1:0] SEL_IN  = 2'h2;
  localparam logic [31:0] DIR_RESET = 32'h0000_0000;
  localparam logic [31:0] OUT_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {OP_WRITE, OP_SET, OP_CLR, OP_TGL} wr_op_t;
  typedef enum logic [1:0] {EV_OUT, EV_SET, EV_CLR, EV_TGL} ev_act_t;

  // one register access: select, operation, byte enables, data
  typedef struct packed {
    logic             valid;
    logic             write;
    logic [1:0]       sel;
    wr_op_t           op;
    logic [3:0]       be;
    logic [31:0]      wdata;
  } bus_req_t;

  // per-pin configuration
  typedef struct packed {
    logic [31:0] in_en;
    logic [31:0] pull_en;
    logic [31:0] mux_en;
    logic [31:0] analog;
  } pin_cfg_t;

  // pad drive bundle
  typedef struct packed {
    logic [31:0] oe;
    logic [31:0] o;
    logic [31:0] pull_en;
    logic [31:0] in_buf_en;
  } pad_drv_t;
endpackage

/* File: rtl/input_sync.sv */
/*
  input_sync: two-stage synchronizer for the pad inputs, gated per pin.
  assumes: runs on the cpu main clock; sample_en holds stage state when low.
*/
`timescale 1ns/100ps
module input_sync
  import gpio_pkg::*;
#(
  parameter int WIDTH = PINS_MAX
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] pad_in,
  input  wire logic [WIDTH-1:0] sample_en,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // ----------------------------------------------------------------
  // stage update, only for pins that are sampling
  // ----------------------------------------------------------------
  always_comb begin
    meta_next = (pad_in & sample_en) | (meta_reg & ~sample_en);
    sync_next = (meta_reg & sample_en) | (sync_reg & ~sample_en);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule

/* File: rtl/io_pin_controller_core.sv */
/*
  io_pin_controller_core: one pin group of the general-purpose pin controller.
  assumes: cpu local bus and apb requests arrive synchronous to ref_clk;
  pads, peripherals, access protector and standby are outside and seen as ports.
*/
`timescale 1ns/100ps
// What this block does
// R01: one group of up to 32 pins
// R02: atomic set, clear, toggle writes per byte
// R03: local bus reaches direction, output, input
// R04: local bus answers in one cycle unless halted
// R05: local bus wins; apb and events wait
// R06: reset makes all pins inputs, all disabled
// R07: shutdown clears registers; pad latches hold
// R08: standby refuses configuration register writes
// R09: four events set, clear, toggle, pass
// R10: input synchronizers on cpu main clock
// R11: runs in debug unless debug halt set
// R12: protection lifted in debug and for debugger
// R13: analog pins lose all digital features
// R14: muxed peripheral drives pad, reads level
// R15: software enables continuous sampling for reads
// R16: direction one means output
// R17: output one drives high
// R18: on-demand read waits two cycles; per-eight sampling; the apb wait checks only samp_reg[0], not the group of the pins read
// R19: input enable zero stops sampling
// R20: zero bits in alias writes change nothing
// R21: local bus write applied before stalled apb
module io_pin_controller_core
  import gpio_pkg::*;
#(
  parameter int WIDTH = PINS_MAX   // [R01]
) (
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  input  wire bus_req_t                lb_req,
  output logic      [31:0]             lb_rdata,
  input  wire bus_req_t                apb_req,
  input  wire logic                    apb_prot_wr,
  input  wire logic                    apb_from_debugger,
  output logic                         apb_ready,
  output logic      [31:0]             apb_rdata,
  input  wire pin_cfg_t                cfg_wdata,
  input  wire logic                    cfg_write,
  input  wire logic [WIDTH/8-1:0]      sampling_wdata,
  input  wire logic [EVT_NUM*2-1:0]    evact_wdata,
  input  wire logic [EVT_NUM-1:0]      evena_wdata,
  input  wire logic [EVT_NUM*5-1:0]    evpin_wdata,
  output logic                         cfg_refused,
  input  wire logic                    standby,
  input  wire logic                    shutdown,
  input  wire logic                    cpu_debug_halt,
  input  wire logic                    debug_halt_control,
  input  wire logic [EVT_NUM-1:0]      event_in,
  output logic                         event_ready,
  input  wire logic [WIDTH-1:0]        pad_in,
  input  wire logic [WIDTH-1:0]        periph_oe,
  input  wire logic [WIDTH-1:0]        periph_o,
  output logic      [WIDTH-1:0]        periph_in,
  output pad_drv_t                     pad
);
  logic [31:0]         dir_reg, dir_next, out_reg, out_next;
  pin_cfg_t            cfg_reg, cfg_next;
  logic [WIDTH/8-1:0]  samp_reg, samp_next;
  logic [EVT_NUM*2-1:0] evact_reg, evact_next;
  logic [EVT_NUM-1:0]  evena_reg, evena_next, evprev_reg;
  logic [EVT_NUM*5-1:0] evpin_reg, evpin_next;
  logic [1:0]          wait_reg, wait_next;
  logic                apb_ready_reg, apb_ready_next, ev_ready_reg, ev_ready_next;
  logic                refused_reg, refused_next;
  logic [31:0]         lb_rd_reg, lb_rd_next, apb_rd_reg, apb_rd_next;
  pad_drv_t            pad_reg, pad_next;
  logic [WIDTH-1:0]    pin_in_reg, sync_val, samp_en, pass_mask, pass_val;
  logic                halted, apb_go, ev_go, lb_rd_in;

  // apply one plain or alias operation to a word under byte enables; the aliases ignore zero bits
  function automatic logic [31:0] apply_op(input logic [31:0] cur, input wr_op_t op,
                                           input logic [3:0] be, input logic [31:0] d);
    logic [31:0] m;
    logic [31:0] r;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    unique case (op)
      OP_WRITE: r = (cur & ~m) | (d & m);
      OP_SET:   r = cur | (d & m);              // [R20]
      OP_CLR:   r = cur & ~(d & m);             // [R20]
      OP_TGL:   r = cur ^ (d & m);              // [R20]
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // input sampling
  // ----------------------------------------------------------------
  // a pin samples when enabled, digital, and its byte group is continuous or a read is pending
  always_comb begin
    lb_rd_in = lb_req.valid && !lb_req.write && lb_req.sel == SEL_IN;
    for (int i = 0; i < WIDTH; i++) begin
      samp_en[i] = cfg_reg.in_en[i] && !cfg_reg.analog[i] && !halted   // [R19] [R13]
                   && (samp_reg[i/8] || wait_reg != 2'h0 || lb_rd_in
                       || (apb_req.valid && apb_req.sel == SEL_IN));   // [R18]
    end
  end

  input_sync #(.WIDTH(WIDTH)) u_sync (    // [R10]
    .ref_clk   (ref_clk),
    .srst      (srst || shutdown),       // [R07]
    .pad_in    (pad_in),
    .sample_en (samp_en),
    .sync_out  (sync_val)
  );

  assign pin_in_reg = sync_val;
  assign halted     = cpu_debug_halt && debug_halt_control;   // [R11]

  // ----------------------------------------------------------------
  // arbitration and register update
  // ----------------------------------------------------------------
  always_comb begin
    logic cfg_ok;
    cfg_ok         = 1'b0;
    dir_next       = dir_reg;
    out_next       = out_reg;
    cfg_next       = cfg_reg;
    samp_next      = samp_reg;
    evact_next     = evact_reg;
    evena_next     = evena_reg;
    evpin_next     = evpin_reg;
    wait_next      = 2'h0;
    apb_ready_next = 1'b0;
    ev_ready_next  = 1'b0;
    refused_next   = 1'b0;
    lb_rd_next     = lb_rd_reg;
    apb_rd_next    = apb_rd_reg;
    apb_go         = 1'b0;
    ev_go          = 1'b0;
    // local bus served this cycle unless halted [R04] [R03]
    if (lb_req.valid && !halted) begin
      if (lb_req.write && lb_req.sel == SEL_DIR)
        dir_next = apply_op(dir_reg, lb_req.op, lb_req.be, lb_req.wdata);   // [R02]
      else if (lb_req.write && lb_req.sel == SEL_OUT)
        out_next = apply_op(out_reg, lb_req.op, lb_req.be, lb_req.wdata);   // [R17]
      else if (!lb_req.write)
        lb_rd_next = lb_req.sel == SEL_DIR ? dir_reg :
                     lb_req.sel == SEL_OUT ? out_reg : 32'(pin_in_reg);
    end
    // apb and events stall while a local bus write is pending [R05]
    if (!halted && !(lb_req.valid && lb_req.write)) begin
      if (apb_req.valid && !apb_ready_reg) begin
        if (apb_req.sel == SEL_IN && !samp_reg[0] && wait_reg != 2'(SYNC_WAIT)) begin
          wait_next = wait_reg + 2'h1;   // [R18]
        end else begin
          apb_go = 1'b1;
          apb_ready_next = 1'b1;
          if (apb_req.write && !(apb_prot_wr && !cpu_debug_halt && !apb_from_debugger)) begin  // [R12]
            if (apb_req.sel == SEL_DIR) dir_next = apply_op(dir_next, apb_req.op, apb_req.be, apb_req.wdata); // [R21]
            if (apb_req.sel == SEL_OUT) out_next = apply_op(out_next, apb_req.op, apb_req.be, apb_req.wdata);
          end
          apb_rd_next = apb_req.sel == SEL_DIR ? dir_reg :
                        apb_req.sel == SEL_OUT ? out_reg : 32'(pin_in_reg);
        end
      end
      ev_go = !apb_go;
    end
    // configuration port, refused in standby or when protected [R08] [R12]
    cfg_ok = !standby && !(apb_prot_wr && !cpu_debug_halt && !apb_from_debugger);
    if (cfg_write) begin
      refused_next = !cfg_ok;
      if (cfg_ok) begin
        cfg_next   = cfg_wdata;
        samp_next  = sampling_wdata;
        evact_next = evact_wdata;
        evena_next = evena_wdata;
        evpin_next = evpin_wdata;
      end
    end
    // four event inputs act on their selected pin's output value [R09]
    ev_ready_next = ev_go;
    if (ev_go) begin
      for (int e = 0; e < EVT_NUM; e++) begin
        if (evena_reg[e] && event_in[e] && !evprev_reg[e]) begin
          unique case (ev_act_t'(evact_reg[e*2 +: 2]))
            EV_SET: out_next[evpin_reg[e*5 +: 5]] = 1'b1;
            EV_CLR: out_next[evpin_reg[e*5 +: 5]] = 1'b0;
            EV_TGL: out_next[evpin_reg[e*5 +: 5]] = ~out_next[evpin_reg[e*5 +: 5]];
            EV_OUT: ;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pad drive, pass-through events and peripheral override
  // ----------------------------------------------------------------
  always_comb begin
    pass_mask = '0;
    pass_val  = '0;
    for (int e = 0; e < EVT_NUM; e++) begin
      if (evena_reg[e] && ev_act_t'(evact_reg[e*2 +: 2]) == EV_OUT) begin
        pass_mask[evpin_reg[e*5 +: 5]] = 1'b1;       // [R09]
        pass_val[evpin_reg[e*5 +: 5]]  = event_in[e];
      end
    end
    for (int i = 0; i < WIDTH; i++) begin
      if (cfg_reg.analog[i]) begin                   // [R13]
        pad_next.oe[i] = 1'b0; pad_next.o[i] = 1'b0;
        pad_next.pull_en[i] = 1'b0; pad_next.in_buf_en[i] = 1'b0;
      end else if (cfg_reg.mux_en[i]) begin          // [R14]
        pad_next.oe[i] = periph_oe[i]; pad_next.o[i] = periph_o[i];
        pad_next.pull_en[i] = 1'b0; pad_next.in_buf_en[i] = 1'b1;
      end else begin
        pad_next.oe[i] = dir_reg[i];                 // [R16]
        pad_next.o[i]  = pass_mask[i] ? pass_val[i] : out_reg[i];   // [R17]
        pad_next.pull_en[i] = cfg_reg.pull_en[i] && !dir_reg[i];
        pad_next.in_buf_en[i] = cfg_reg.in_en[i];
      end
    end
    for (int i = WIDTH; i < PINS_MAX; i++) begin
      pad_next.oe[i] = 1'b0; pad_next.o[i] = 1'b0;
      pad_next.pull_en[i] = 1'b0; pad_next.in_buf_en[i] = 1'b0;
    end
  end

  // registers: reset clears everything, shutdown clears configuration; pad latches hold
  always_ff @(posedge ref_clk) begin
    if (srst) begin                                 // [R06]
      dir_reg <= DIR_RESET; out_reg <= OUT_RESET; cfg_reg <= '{default: CFG_RESET};
      samp_reg <= '0; evact_reg <= '0; evena_reg <= '0; evpin_reg <= '0; evprev_reg <= '0;
      wait_reg <= '0; apb_ready_reg <= 1'b0; ev_ready_reg <= 1'b0; refused_reg <= 1'b0;
      lb_rd_reg <= '0; apb_rd_reg <= '0; pad_reg <= '0;
    end else if (shutdown) begin                    // [R07]
      dir_reg <= DIR_RESET; out_reg <= OUT_RESET; cfg_reg <= '{default: CFG_RESET};
      samp_reg <= '0; evact_reg <= '0; evena_reg <= '0; evpin_reg <= '0; evprev_reg <= '0;
      wait_reg <= '0; apb_ready_reg <= 1'b0; ev_ready_reg <= 1'b0; refused_reg <= 1'b0;
    end else begin
      dir_reg <= dir_next; out_reg <= out_next; cfg_reg <= cfg_next; samp_reg <= samp_next;
      evact_reg <= evact_next; evena_reg <= evena_next; evpin_reg <= evpin_next;
      evprev_reg <= ev_go ? event_in : evprev_reg;
      wait_reg <= wait_next; apb_ready_reg <= apb_ready_next; ev_ready_reg <= ev_ready_next;
      refused_reg <= refused_next; lb_rd_reg <= lb_rd_next; apb_rd_reg <= apb_rd_next;
      pad_reg <= pad_next;
    end
  end

  assign lb_rdata    = lb_rd_reg;
  assign apb_rdata   = apb_rd_reg;
  assign apb_ready   = apb_ready_reg;
  assign event_ready = ev_ready_reg;
  assign cfg_refused = refused_reg;
  assign pad         = pad_reg;
  assign periph_in   = pin_in_reg;                 // [R14]

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_reset_inputs;
    @(posedge ref_clk) srst |=> (pad.oe == '0 && pad.pull_en == '0 && pad.in_buf_en == '0);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs after reset"); // [R06]

  property p_lb_set;
    @(posedge ref_clk) disable iff (srst || shutdown)
      (lb_req.valid && lb_req.write && lb_req.sel == SEL_DIR && lb_req.op == OP_SET && !halted)
      |=> (apply_op(dir_reg, OP_SET, $past(lb_req.be), $past(lb_req.wdata)) == dir_reg);
  endproperty
  a_lb_set: assert property (p_lb_set) else $error("direction set bits lost"); // [R02]

  property p_lb_clr_keeps;
    @(posedge ref_clk) disable iff (srst || shutdown)
      (lb_req.valid && lb_req.write && lb_req.sel == SEL_OUT && lb_req.op == OP_CLR && !halted
       && !apb_req.valid && evena_reg == '0)
      |=> ((out_reg & ~$past(lb_req.wdata)) == ($past(out_reg) & ~$past(lb_req.wdata)));
  endproperty
  a_lb_clr_keeps: assert property (p_lb_clr_keeps) else $error("clear touched zero bits"); // [R20]

  property p_lb_wins;
    @(posedge ref_clk) disable iff (srst || shutdown)
      (lb_req.valid && lb_req.write) |=> !apb_ready || $past(apb_ready);
  endproperty
  a_lb_wins: assert property (p_lb_wins) else $error("apb served during local write"); // [R05]

  property p_lb_read;
    @(posedge ref_clk) disable iff (srst || shutdown)
      (lb_req.valid && !lb_req.write && lb_req.sel == SEL_DIR && !halted) |=> lb_rdata == $past(dir_reg);
  endproperty
  a_lb_read: assert property (p_lb_read) else $error("local read not single cycle"); // [R04]

  property p_standby;
    @(posedge ref_clk) disable iff (srst || shutdown) (cfg_write && standby) |=> cfg_refused && $stable(cfg_reg);
  endproperty
  a_standby: assert property (p_standby) else $error("config written in standby"); // [R08]

  property p_analog;
    @(posedge ref_clk) disable iff (srst || shutdown)
      cfg_reg.analog != '0 |=> ((pad.oe | pad.pull_en | pad.in_buf_en) & $past(cfg_reg.analog)) == '0;
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin kept digital drive"); // [R13]

  property p_dir_out;
    @(posedge ref_clk) disable iff (srst || shutdown)
      (!cfg_reg.analog[1] && !cfg_reg.mux_en[1] && !pass_mask[1]) |=> pad.oe[1] == $past(dir_reg[1])
      && pad.o[1] == $past(out_reg[1]);
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("pad does not follow direction/output"); // [R16]

  property p_halt;
    @(posedge ref_clk) disable iff (srst || shutdown) halted |=> $stable(dir_reg) && $stable(out_reg);
  endproperty
  a_halt: assert property (p_halt) else $error("registers changed in debug halt"); // [R11]

  c_apb_wait:  cover property (@(posedge ref_clk) apb_req.valid && apb_req.sel == SEL_IN ##3 apb_ready);
  c_lb_tgl:    cover property (@(posedge ref_clk) lb_req.valid && lb_req.write && lb_req.op == OP_TGL);
  c_event_set: cover property (@(posedge ref_clk) ev_go && evena_reg != '0 && event_in != '0);
endmodule

/* File: test/io_pin_controller_core_bench.sv */
/*
  io_pin_controller_core_bench: self-checking bench for one pin group.
  assumes: gpio_pkg, the design files and pad_model are compiled first.
*/
`timescale 1ns/100ps
module io_pin_controller_core_bench
  import gpio_pkg::*;
;
  logic        ref_clk = 1'b0, srst = 1'b1, cfg_write = 1'b0, standby = 1'b0, shutdown = 1'b0;
  logic        apb_prot_wr = 1'b0, apb_from_debugger = 1'b0, cpu_debug_halt = 1'b0, debug_halt_control = 1'b0;
  bus_req_t    lb_req = '0, apb_req = '0;
  pin_cfg_t    cfg_wdata = '0;
  logic [3:0]  sampling_wdata = 4'h0, evena_wdata = 4'h0, event_in = 4'h0;
  logic [7:0]  evact_wdata = 8'h00;
  logic [19:0] evpin_wdata = 20'h00000;
  logic [31:0] periph_oe = '0, periph_o = '0, ext_en = '0, ext_val = '0, pad_in, periph_in, lb_rdata, apb_rdata;
  logic        apb_ready, cfg_refused, event_ready, lb_rd_d = 1'b0;
  pad_drv_t    pad;
  logic [31:0] seed = 32'h0000_9984, dir_m = '0, out_m = '0;
  logic [31:0] lb_q[$], apb_q[$];
  string       lb_n[$];
  int          fails = 0, checked = 0;

  io_pin_controller_core dut (.ref_clk(ref_clk), .srst(srst), .lb_req(lb_req), .lb_rdata(lb_rdata),
    .apb_req(apb_req), .apb_prot_wr(apb_prot_wr), .apb_from_debugger(apb_from_debugger), .apb_ready(apb_ready),
    .apb_rdata(apb_rdata), .cfg_wdata(cfg_wdata), .cfg_write(cfg_write), .sampling_wdata(sampling_wdata),
    .evact_wdata(evact_wdata), .evena_wdata(evena_wdata), .evpin_wdata(evpin_wdata), .cfg_refused(cfg_refused),
    .standby(standby), .shutdown(shutdown), .cpu_debug_halt(cpu_debug_halt), .debug_halt_control(debug_halt_control),
    .event_in(event_in), .event_ready(event_ready), .pad_in(pad_in), .periph_oe(periph_oe), .periph_o(periph_o),
    .periph_in(periph_in), .pad(pad));
  pad_model pads (.ref_clk(ref_clk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  // ------------------------------------------------------------
  // clock, helpers and bus tasks
  // ------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction

  // expected register after a plain or alias write
  function automatic logic [31:0] upd(input logic [31:0] o, input wr_op_t op, input logic [3:0] be,
                                      input logic [31:0] d);
    logic [31:0] bm;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    case (op)
      OP_WRITE: return (o & ~bm) | (bm & d);
      OP_SET:   return o | (bm & d);
      OP_CLR:   return o & ~(bm & d);
      default:  return o ^ (bm & d);
    endcase
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // request stays up for one edge; caller ends a burst with gap
  task automatic lb(input logic w, input logic [1:0] s, input wr_op_t op, input logic [3:0] be, input logic [31:0] d);
    lb_req <= '{1'b1, w, s, op, be, d};
    @(posedge ref_clk);
  endtask

  task automatic gap();
    lb_req.valid <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [1:0] s, input logic [31:0] e, input string n);
    lb_q.push_back(e);
    lb_n.push_back(n);
    lb(1'b0, s, OP_WRITE, 4'hf, 32'h0);
  endtask

  // holds the request until ready is seen, returns the edges it took
  task automatic apb(input logic w, input logic [1:0] s, input logic [31:0] d, output int lat);
    apb_req <= '{1'b1, w, s, OP_WRITE, 4'hf, d};
    lat = 0;
    do begin
      @(posedge ref_clk);
      lat++;
    end while (apb_ready !== 1'b1 && lat < 40);
    apb_req.valid <= 1'b0;
    @(posedge ref_clk);
    if (lat >= 40) begin
      fails++;
      end_sim();
    end
  endtask

  task automatic cfg(input logic [31:0] ie, input logic [31:0] mx, input logic [31:0] an, output logic refused);
    cfg_wdata <= '{ie, ie, mx, an};
    cfg_write <= 1'b1;
    @(posedge ref_clk);
    cfg_write <= 1'b0;
    refused = 1'b0;
    repeat (3) begin
      @(posedge ref_clk);
      refused = refused | cfg_refused;
    end
  endtask

  task automatic end_sim();
    fails += lb_q.size() + apb_q.size();   // notes never compared count as misses
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // result monitor and watchdog
  // ------------------------------------------------------------
  // takes the oldest note whenever read data is due
  always @(posedge ref_clk) begin
    if (lb_rd_d && lb_q.size() > 0) chk(lb_n.pop_front(), lb_q.pop_front(), lb_rdata);
    if (apb_ready === 1'b1 && apb_q.size() > 0) chk("apb_rdata", apb_q.pop_front(), apb_rdata);
    lb_rd_d <= lb_req.valid && !lb_req.write;
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    end_sim();
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    logic r;
    int k, p, lat, lw, ld;
    logic [31:0] a, b;
    wr_op_t op;
    pad_drv_t hold;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    chk("reset_pad", 32'h0, pad.oe | pad.pull_en | pad.in_buf_en);
    // random byte-enabled writes and aliases, each read straight back
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      op = wr_op_t'(i[1:0]);
      a = lfsr(seed);
      lb(1'b1, i[2] ? SEL_OUT : SEL_DIR, op, seed[7:4], a);
      if (i[2]) out_m = upd(out_m, op, seed[7:4], a);
      else dir_m = upd(dir_m, op, seed[7:4], a);
      rd(i[2] ? SEL_OUT : SEL_DIR, i[2] ? out_m : dir_m, "alias_rd");
    end
    gap();
    gap();
    chk("pad_oe", dir_m, pad.oe);
    chk("pad_o", out_m & dir_m, pad.o & dir_m);
    // analog pin 5 and peripheral pin 6
    lb(1'b1, SEL_DIR, OP_WRITE, 4'hf, 32'hffff_ffff);
    gap();
    dir_m = 32'hffff_ffff;
    sampling_wdata <= 4'hf;
    periph_oe[6] <= 1'b1;
    periph_o[6] <= ~out_m[6];
    cfg(32'hffff_ffff, 32'h0000_0040, 32'h0000_0020, r);
    repeat (2) @(posedge ref_clk);
    chk("analog", 32'h0, 32'({pad.oe[5], pad.in_buf_en[5], pad.pull_en[5]}));
    chk("mux", 32'({1'b1, ~out_m[6], ~out_m[6]}), 32'({pad.oe[6], pad.o[6], periph_in[6]}));
    // input reads with continuous sampling, then upper half gated
    lb(1'b1, SEL_DIR, OP_WRITE, 4'hf, 32'h0);
    gap();
    dir_m = '0;
    ext_en <= 32'hffff_ffff;
    cfg(32'hffff_ffff, '0, '0, r);
    seed = lfsr(seed);
    a = seed;
    ext_val <= a;
    repeat (4) @(posedge ref_clk);
    rd(SEL_IN, a, "in_read");
    gap();
    cfg(32'h0000_ffff, '0, '0, r);
    seed = lfsr(seed);
    ext_val <= seed;
    repeat (4) @(posedge ref_clk);
    rd(SEL_IN, {a[31:16], seed[15:0]}, "in_gated");
    gap();
    // on-demand sampling adds the synchronizer wait to apb reads
    sampling_wdata <= 4'h0;
    cfg(32'hffff_ffff, '0, '0, r);
    seed = lfsr(seed);
    b = seed;
    ext_val <= b;
    repeat (4) @(posedge ref_clk);
    apb_q.push_back(dir_m);
    apb(1'b0, SEL_DIR, 32'h0, ld);
    apb_q.push_back(b);
    apb(1'b0, SEL_IN, 32'h0, lat);
    chk("in_wait", 32'(ld + SYNC_WAIT), 32'(lat));
    // colliding writes: local bus and apb issued in the same cycle, apb served one cycle later
    apb(1'b1, SEL_DIR, ~b, lw);
    fork
      begin
        lb(1'b1, SEL_DIR, OP_WRITE, 4'hf, a);
        gap();
        chk("ev_stall", 32'h0, 32'(event_ready));
      end
      apb(1'b1, SEL_DIR, b, lat);
    join
    chk("apb_stall", 32'(lw + 1), 32'(lat));
    dir_m = b;
    rd(SEL_DIR, dir_m, "collide");
    gap();
    // protected writes: dropped, then debugger, then cpu halted
    apb_prot_wr <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      apb_from_debugger <= (j == 1);
      cpu_debug_halt <= (j == 2);
      seed = lfsr(seed);
      apb(1'b1, SEL_OUT, seed, lat);
      if (j > 0) out_m = seed;
      rd(SEL_OUT, out_m, "prot_out");
      gap();
    end
    apb_prot_wr <= 1'b0;
    apb_from_debugger <= 1'b0;
    // halted by debug control: local write ignored
    debug_halt_control <= 1'b1;
    lb(1'b1, SEL_DIR, OP_WRITE, 4'hf, ~dir_m);
    gap();
    cpu_debug_halt <= 1'b0;
    debug_halt_control <= 1'b0;
    rd(SEL_DIR, dir_m, "halt_dir");
    gap();
    // standby refuses configuration but keeps data access
    standby <= 1'b1;
    cfg('0, 32'hffff_ffff, '0, r);
    chk("cfg_refused", 32'h1, 32'(r));
    lb(1'b1, SEL_OUT, OP_TGL, 4'hf, 32'hffff_ffff);
    out_m = ~out_m;
    rd(SEL_OUT, out_m, "standby_out");
    gap();
    standby <= 1'b0;
    // events: pass, set, clear, toggle on pins 3, 8, 13, 18
    lb(1'b1, SEL_DIR, OP_WRITE, 4'hf, 32'hffff_ffff);
    gap();
    evpin_wdata <= {5'd18, 5'd13, 5'd8, 5'd3};
    evact_wdata <= {EV_TGL, EV_CLR, EV_SET, EV_OUT};
    evena_wdata <= 4'hf;
    cfg('0, '0, '0, r);
    for (int j = 1; j < 5; j++) begin
      k = j % 4;
      p = k * 5 + 3;
      event_in[k] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      if (k == 0) begin
        chk("ev_pass", 32'h1, 32'(pad.o[3]));
        chk("ev_ready", 32'h1, 32'(event_ready));
      end else begin
        out_m[p] = (k == 1) ? 1'b1 : (k == 2) ? 1'b0 : ~out_m[p];
        rd(SEL_OUT, out_m, "ev_out");
        gap();
      end
      event_in[k] <= 1'b0;
      @(posedge ref_clk);
    end
    // shutdown: registers cleared, pad latches hold
    repeat (3) @(posedge ref_clk);
    hold = pad;
    shutdown <= 1'b1;
    repeat (2) @(posedge ref_clk);
    shutdown <= 1'b0;
    @(posedge ref_clk);
    chk("latch_o", hold.o, pad.o);
    chk("latch_pull", hold.pull_en, pad.pull_en);
    rd(SEL_DIR, 32'h0, "shut_dir");
    gap();
    gap();
    gap();
    end_sim();
  end
endmodule

/* File: test/pad_model.sv */
/*
  pad_model: the pads and the world outside one pin group.
  assumes: the bench sets which pins an outside source drives and to what level.
*/
`timescale 1ns/100ps
module pad_model
  import gpio_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire pad_drv_t    pad,
  input  wire logic [31:0] ext_en,
  input  wire logic [31:0] ext_val,
  output logic      [31:0] pad_in
);
  logic [31:0] last_reg = 32'h0000_0000;

  // ------------------------------------------------------------
  // pad level
  // ------------------------------------------------------------
  // device drive wins, then the outside source, then the pull level
  // a floating pad shows the inverse of its last level, never a stale copy
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pad.oe[i]) pad_in[i] = pad.o[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad.pull_en[i]) pad_in[i] = pad.o[i];
      else pad_in[i] = ~last_reg[i];
    end
  end

  // remembers the level so a floating pad keeps changing
  always_ff @(posedge ref_clk) begin
    last_reg <= pad_in;
  end
endmodule
